// ===== inc/lcc_consts.vh
// Constants of the line channel control block
// Operation
// R1: Short protection, fault status, irq status and mask work only when enabled.
// R2: Driver short monitor sets the channel's driver fault status bit.
// R3: A detected short sets fault irq status and drives interrupt low.
// R4: Hardware mode: transmit clock high over 16 master clocks sends all ones.
// R5: Host mode: all-ones config register bits send all ones per channel.
// R6: Auto all-ones bit plus carrier absent inserts all ones on transmit.
// R7: All-ones pattern is timed from the master clock.
// R8: Channel 0 monitors any channel 1..7, by pins or monitor select register.
// R9: Monitored signal appears on channel 0 clock and raw outputs, feeds CARRIER_ABSENT.
// R10: Remote loopback drives monitored signal on channel 0 transmit, recovered clock.
// R11: Remote loopback works only in host mode.
// R12: Host enables loopback with loopback reg 01H, front-end enable FEH.
// R13: Host sets loopback reg 00H, front-end enable FFH for normal use.
// R14: Any soft reset register write starts a 1 us reset of all registers.
// R15: Power-up holds internal reset at least 10 us.
// R16: Transmit clock low over 64 master clocks powers down that transmitter.
// R17: Host mode: transmit power-down register bit powers down transmitter.
// R18: Master clock low powers all receivers down; else per-bit receiver power-down.
// R19: Top strap mid-supply selects serial host bus, high selects parallel.
// R20: Host programs front-end enable register to FFH in host mode.
// R21: Parallel mode: middle strap muxed bus, lowest strap strobe style.
// R22: Masked-in status change sets irq status and drives interrupt low.
// R23: Reading status clears irq status; interrupt releases when none pending.
// R24: Writing AAH to bank pointer selects expanded bank; clearing restores primary.
// R25: Each transmit clock edge restarts its high and low time counters.
`ifndef LCC_CONSTS_VH
`define LCC_CONSTS_VH
`define LCC_A_ID 5'h00
`define LCC_A_LOOP 5'h02
`define LCC_A_AONES 5'h03
`define LCC_A_LOS 5'h04
`define LCC_A_DF 5'h05
`define LCC_A_LOSM 5'h06
`define LCC_A_DFM 5'h07
`define LCC_A_LOSI 5'h08
`define LCC_A_DFI 5'h09
`define LCC_A_RST 5'h0A
`define LCC_A_MON 5'h0B
`define LCC_A_AUTO 5'h0E
`define LCC_A_GCF 5'h0F
`define LCC_A_PTR 5'h1F
`define LCC_FRONT_END_ENABLE_REG 5'h02
`define LCC_RX_POWERDOWN_REG 5'h03
`define LCC_TX_POWERDOWN_REG 5'h04
`define LCC_PTR_EXP 8'hAA
`define LCC_GCF_SCP_BIT 0
// Device code is an arbitrary neutral value
`define LCC_ID_VALUE 8'h5C
`define LCC_AFE_RST 8'h00
`define LCC_HI_CYC 16
`define LCC_LO_CYC 64
`define LCC_CLK_MHZ 100
`define LCC_SRST_US 1
`define LCC_POR_US 10
`define LCC_SRST_CYC (`LCC_SRST_US * `LCC_CLK_MHZ)
`define LCC_POR_CYC (`LCC_POR_US * `LCC_CLK_MHZ)
`define LCC_STRAP_MID 2'b01
`define LCC_STRAP_HIGH 2'b10
`endif

// ===== verilog/lcc_clk_watch.v
// Per-channel transmit clock high and low time watcher
`timescale 1ns/1ps
`include "lcc_consts.vh"
module lcc_clk_watch (
  input wire clock_i,
  input wire rst_i,
  input wire mclk_i,
  input wire tclk_i,
  output reg stuck_high_o,
  output reg stuck_low_o
);
  reg tclk_d;
  reg mclk_d;
  reg [6:0] hi_cnt;
  reg [6:0] lo_cnt;
  wire mclk_rise;
  wire tclk_edge;
  assign mclk_rise = mclk_i & ~mclk_d;
  assign tclk_edge = tclk_i ^ tclk_d;
  // Counts master clock periods between transmit clock edges
  always @(posedge clock_i) begin
    tclk_d <= tclk_i;
    mclk_d <= mclk_i;
    if (rst_i) begin
      hi_cnt <= 7'h00;
      lo_cnt <= 7'h00;
      stuck_high_o <= 1'b0;
      stuck_low_o <= 1'b0;
    end else if (tclk_edge) begin
      hi_cnt <= 7'h00; // R25
      lo_cnt <= 7'h00; // R25
      stuck_high_o <= 1'b0;
      stuck_low_o <= 1'b0;
    end else if (mclk_rise) begin
      if (tclk_i && hi_cnt <= 7'd`LCC_HI_CYC)
        hi_cnt <= hi_cnt + 7'h01;
      if (!tclk_i && lo_cnt <= 7'd`LCC_LO_CYC)
        lo_cnt <= lo_cnt + 7'h01;
      stuck_high_o <= tclk_i && hi_cnt >= 7'd`LCC_HI_CYC; // R4
      stuck_low_o <= !tclk_i && lo_cnt >= 7'd`LCC_LO_CYC; // R16
    end
  end
endmodule

// ===== verilog/lcc_top.v
// Line channel control: registers, all ones, power down, monitoring
`timescale 1ns/1ps
`include "lcc_consts.vh"
module lcc_top (
  input wire clock_i,
  input wire nrst_i,
  input wire [4:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [1:0] host_kind_strap_i,
  input wire bus_mux_strap_i,
  input wire bus_style_strap_i,
  input wire mclk_i,
  input wire [7:0] chan_tx_clock_i,
  input wire [7:0] driver_short_monitor_i,
  input wire [7:0] carrier_absent_i,
  input wire [3:0] monitor_select_pins_i,
  input wire [7:0] tx_data_pos_i,
  input wire [7:0] tx_data_neg_i,
  input wire [7:0] rx_raw_pos_i,
  input wire [7:0] rx_raw_neg_i,
  input wire [7:0] rx_clock_i,
  input wire chan0_recovered_clk_i,
  output wire [7:0] tx_line_pos_out_o,
  output wire [7:0] tx_line_neg_out_o,
  output wire chan0_clock_out_o,
  output wire chan0_raw_pos_out_o,
  output wire chan0_raw_neg_out_o,
  output wire chan0_los_in_o,
  output wire [7:0] tx_powered_down_o,
  output wire [7:0] rx_powered_down_o,
  output wire [7:0] short_limit_on_o,
  output wire host_mode_o,
  output wire serial_bus_o,
  output wire muxed_bus_o,
  output wire rw_strobe_style_o,
  output wire irq_n_o
);
  reg [7:0] remote_loopback_reg;
  reg [7:0] all_ones_config_reg;
  reg [7:0] driver_fault_irq_mask;
  reg [7:0] los_irq_mask;
  reg [7:0] driver_fault_status;
  reg [7:0] carrier_status;
  reg [7:0] driver_fault_irq_status;
  reg [7:0] los_irq_status;
  reg [7:0] monitor_select_reg;
  reg [7:0] auto_all_ones_reg;
  reg [7:0] global_config_reg;
  reg [7:0] bank_pointer_reg;
  reg [7:0] front_end_enable_reg;
  reg [7:0] rx_powerdown_reg;
  reg [7:0] tx_powerdown_reg;
  reg [10:0] rst_cnt;
  reg [7:0] next_rdata;
  reg [7:0] next_los_mon;
  reg [1:0] strap_kind;
  reg strap_mux;
  reg strap_style;
  reg strap_done;
  reg mclk_q;
  reg [7:0] mclk_hold;
  reg mclk_low;
  reg mclk_running;
  reg [7:0] aones_pos;
  wire int_rst;
  wire expanded;
  wire scp_on;
  wire [7:0] stuck_high;
  wire [7:0] stuck_low;
  wire [7:0] send_ones;
  wire [2:0] mon_chan;
  wire mon_rx;
  wire mon_on;
  wire loop_on;
  wire mon_pos;
  wire mon_neg;
  wire mon_clk;
  wire [7:0] df_change;
  wire [7:0] los_change;
  genvar g;
  // Reset loads kept 32 bits wide, cut to the counter on purpose
  localparam [31:0] POR_LOAD = `LCC_POR_CYC;
  localparam [31:0] SRST_LOAD = `LCC_SRST_CYC;

  // Internal reset: power-on hold, soft reset and the pin
  always @(posedge clock_i) begin
    if (!nrst_i)
      rst_cnt <= POR_LOAD[10:0]; // R15
    else if (wr_i && !int_rst && !expanded && addr_i == `LCC_A_RST)
      rst_cnt <= SRST_LOAD[10:0]; // R14
    else if (rst_cnt != 11'h000)
      rst_cnt <= rst_cnt - 11'h001;
  end
  assign int_rst = !nrst_i || rst_cnt != 11'h000;

  // Strap capture in the first cycle after the reset pin releases
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      strap_done <= 1'b0;
      strap_kind <= 2'b00;
      strap_mux <= 1'b0;
      strap_style <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_kind <= host_kind_strap_i;
      strap_mux <= bus_mux_strap_i;
      strap_style <= bus_style_strap_i;
    end
  end
  assign host_mode_o = strap_kind == `LCC_STRAP_MID ||
                       strap_kind == `LCC_STRAP_HIGH;
  assign serial_bus_o = strap_kind == `LCC_STRAP_MID; // R19
  assign muxed_bus_o = strap_kind == `LCC_STRAP_HIGH && strap_mux; // R21
  assign rw_strobe_style_o = strap_kind == `LCC_STRAP_HIGH &&
                             strap_style; // R21

  // Master clock activity: held low, held high or running
  always @(posedge clock_i) begin
    mclk_q <= mclk_i;
    if (!nrst_i) begin
      mclk_hold <= 8'h00;
      mclk_low <= 1'b0;
      mclk_running <= 1'b0;
    end else if (mclk_i != mclk_q) begin
      mclk_hold <= 8'h00;
      mclk_low <= 1'b0;
      mclk_running <= 1'b1;
    end else if (mclk_hold != 8'hFF) begin
      mclk_hold <= mclk_hold + 8'h01;
    end else begin
      mclk_low <= !mclk_i;
      mclk_running <= 1'b0;
    end
  end

  // Per-channel transmit clock watchers
  generate
    for (g = 0; g < 8; g = g + 1) begin : watch
      lcc_clk_watch u_watch (
        .clock_i(clock_i),
        .rst_i(int_rst),
        .mclk_i(mclk_i),
        .tclk_i(chan_tx_clock_i[g]),
        .stuck_high_o(stuck_high[g]),
        .stuck_low_o(stuck_low[g])
      );
    end
  endgenerate

  assign expanded = bank_pointer_reg == `LCC_PTR_EXP; // R24
  assign scp_on = global_config_reg[`LCC_GCF_SCP_BIT];
  assign short_limit_on_o = {8{scp_on}}; // R1
  assign df_change = scp_on ? (driver_short_monitor_i ^ driver_fault_status)
                            : 8'h00;
  assign los_change = carrier_absent_i ^ carrier_status;

  // Register file writes, status tracking and interrupt flags
  always @(posedge clock_i) begin
    if (int_rst) begin
      remote_loopback_reg <= 8'h00;
      all_ones_config_reg <= 8'h00;
      driver_fault_irq_mask <= 8'h00;
      los_irq_mask <= 8'h00;
      driver_fault_status <= 8'h00;
      carrier_status <= 8'h00;
      driver_fault_irq_status <= 8'h00;
      los_irq_status <= 8'h00;
      monitor_select_reg <= 8'h00;
      auto_all_ones_reg <= 8'h00;
      global_config_reg <= 8'h00;
      bank_pointer_reg <= 8'h00;
      front_end_enable_reg <= `LCC_AFE_RST;
      rx_powerdown_reg <= 8'h00;
      tx_powerdown_reg <= 8'h00;
    end else begin
      if (scp_on)
        driver_fault_status <= driver_short_monitor_i; // R2
      else
        driver_fault_status <= 8'h00; // R1
      carrier_status <= carrier_absent_i;
      // Read clears first, fresh changes win over the clear
      if (rd_i && !expanded && addr_i == `LCC_A_DF)
        driver_fault_irq_status <= df_change & driver_fault_irq_mask; // R23
      else
        driver_fault_irq_status <= driver_fault_irq_status |
          (df_change & driver_fault_irq_mask & {8{scp_on}}); // R3 R22
      if (rd_i && !expanded && addr_i == `LCC_A_LOS)
        los_irq_status <= los_change & los_irq_mask; // R23
      else
        los_irq_status <= los_irq_status |
          (los_change & los_irq_mask); // R22
      if (wr_i && addr_i == `LCC_A_PTR)
        bank_pointer_reg <= wdata_i; // R24
      else if (wr_i && expanded) begin
        case (addr_i)
          `LCC_FRONT_END_ENABLE_REG: front_end_enable_reg <= wdata_i;
          `LCC_RX_POWERDOWN_REG: rx_powerdown_reg <= wdata_i;
          `LCC_TX_POWERDOWN_REG: tx_powerdown_reg <= wdata_i;
          default: ;
        endcase
      end else if (wr_i) begin
        case (addr_i)
          `LCC_A_LOOP: remote_loopback_reg <= {7'h00, wdata_i[0]};
          `LCC_A_AONES: all_ones_config_reg <= wdata_i;
          `LCC_A_LOSM: los_irq_mask <= wdata_i;
          `LCC_A_DFM: driver_fault_irq_mask <= scp_on ? wdata_i : 8'h00;
          `LCC_A_MON: monitor_select_reg <= wdata_i;
          `LCC_A_AUTO: auto_all_ones_reg <= wdata_i;
          `LCC_A_GCF: global_config_reg <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  // Read multiplexer
  always @* begin
    next_rdata = 8'h00;
    if (addr_i == `LCC_A_PTR)
      next_rdata = bank_pointer_reg;
    else if (expanded) begin
      case (addr_i)
        `LCC_FRONT_END_ENABLE_REG: next_rdata = front_end_enable_reg;
        `LCC_RX_POWERDOWN_REG: next_rdata = rx_powerdown_reg;
        `LCC_TX_POWERDOWN_REG: next_rdata = tx_powerdown_reg;
        default: next_rdata = 8'h00;
      endcase
    end else begin
      case (addr_i)
        `LCC_A_ID: next_rdata = `LCC_ID_VALUE;
        `LCC_A_LOOP: next_rdata = remote_loopback_reg;
        `LCC_A_AONES: next_rdata = all_ones_config_reg;
        `LCC_A_LOS: next_rdata = carrier_status;
        `LCC_A_DF: next_rdata = driver_fault_status;
        `LCC_A_LOSM: next_rdata = los_irq_mask;
        `LCC_A_DFM: next_rdata = driver_fault_irq_mask;
        `LCC_A_LOSI: next_rdata = los_irq_status;
        `LCC_A_DFI: next_rdata = driver_fault_irq_status;
        `LCC_A_MON: next_rdata = monitor_select_reg;
        `LCC_A_AUTO: next_rdata = auto_all_ones_reg;
        `LCC_A_GCF: next_rdata = global_config_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe
  always @(posedge clock_i) begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

  // Latched interrupt, low while anything pending
  assign irq_n_o = !(|driver_fault_irq_status || |los_irq_status); // R3 R23

  // All-ones pattern toggles polarity on master clock rises
  always @(posedge clock_i) begin
    if (int_rst)
      aones_pos <= 8'h00;
    else if (mclk_i && !mclk_q)
      aones_pos <= ~aones_pos; // R7
  end

  assign send_ones = (host_mode_o ? all_ones_config_reg : stuck_high) // R4 R5
                   | (auto_all_ones_reg & carrier_absent_i); // R6
  assign tx_powered_down_o = stuck_low |
                             (host_mode_o ? tx_powerdown_reg : 8'h00); // R16 R17
  assign rx_powered_down_o = mclk_low ? 8'hFF : rx_powerdown_reg; // R18

  // Monitor source: bit 3 picks transmit, low bits pick channel
  assign mon_chan = host_mode_o ? monitor_select_reg[2:0]
                                : monitor_select_pins_i[2:0]; // R8
  assign mon_rx = host_mode_o ? !monitor_select_reg[3]
                              : !monitor_select_pins_i[3];
  assign mon_on = mon_chan != 3'h0; // R8
  assign loop_on = mon_on && host_mode_o && remote_loopback_reg[0] &&
                   !front_end_enable_reg[0]; // R10 R11
  assign mon_pos = mon_rx ? rx_raw_pos_i[mon_chan]
                          : tx_line_pos_out_o[mon_chan];
  assign mon_neg = mon_rx ? rx_raw_neg_i[mon_chan]
                          : tx_line_neg_out_o[mon_chan];
  // Clock output of a dual rail stream is the XOR of its rails
  assign mon_clk = mon_pos ^ mon_neg;

  // Channel 0 observes the monitored signal
  assign chan0_raw_pos_out_o = mon_on ? mon_pos : rx_raw_pos_i[0]; // R9
  assign chan0_raw_neg_out_o = mon_on ? mon_neg : rx_raw_neg_i[0]; // R9
  assign chan0_clock_out_o = loop_on ? chan0_recovered_clk_i
                           : (mon_on ? mon_clk : rx_clock_i[0]); // R9 R10
  always @* begin
    next_los_mon = carrier_absent_i;
    next_los_mon[0] = mon_on ? !(mon_pos | mon_neg) : carrier_absent_i[0];
  end
  assign chan0_los_in_o = next_los_mon[0]; // R9

  // Transmit line drive per channel
  generate
    for (g = 0; g < 8; g = g + 1) begin : txd
      if (g == 0) begin : c0
        assign tx_line_pos_out_o[0] = tx_powered_down_o[0] ? 1'b0 :
          loop_on ? mon_pos : send_ones[0] ? aones_pos[0] :
          tx_data_pos_i[0]; // R10
        assign tx_line_neg_out_o[0] = tx_powered_down_o[0] ? 1'b0 :
          loop_on ? mon_neg : send_ones[0] ? !aones_pos[0] :
          tx_data_neg_i[0]; // R10
      end else begin : cn
        assign tx_line_pos_out_o[g] = tx_powered_down_o[g] ? 1'b0 :
          send_ones[g] ? aones_pos[g] : tx_data_pos_i[g]; // R5 R6
        assign tx_line_neg_out_o[g] = tx_powered_down_o[g] ? 1'b0 :
          send_ones[g] ? !aones_pos[g] : tx_data_neg_i[g]; // R5 R6
      end
    end
  endgenerate
endmodule

// ===== test/lcc_asserts.sv
// Port checker of the line channel control block
`timescale 1ns/1ps
module lcc_asserts (
  input wire clock_i,
  input wire nrst_i,
  input wire [1:0] host_kind_strap_i,
  input wire bus_mux_strap_i,
  input wire bus_style_strap_i,
  input wire mclk_i,
  input wire [7:0] chan_tx_clock_i,
  input wire [3:0] monitor_select_pins_i,
  input wire [7:0] rx_raw_pos_i,
  input wire [7:0] rx_raw_neg_i,
  input wire [7:0] rx_clock_i,
  input wire [7:0] tx_line_pos_out_o,
  input wire [7:0] tx_line_neg_out_o,
  input wire chan0_clock_out_o,
  input wire chan0_raw_pos_out_o,
  input wire [7:0] tx_powered_down_o,
  input wire [7:0] rx_powered_down_o,
  input wire host_mode_o,
  input wire serial_bus_o,
  input wire muxed_bus_o,
  input wire rw_strobe_style_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  reg mclk_q;
  reg [8:0] mlow;
  reg [6:0] lo1;
  reg [6:0] hi2;
  wire t1 = chan_tx_clock_i[1];
  wire t2 = chan_tx_clock_i[2];
  wire [2:0] sel = monitor_select_pins_i[2:0];
  wire mrise = mclk_i & ~mclk_q;
  // Master clock low time, stuck counts in master clock rises
  always @(posedge clock_i) begin
    mclk_q <= mclk_i;
    mlow <= (!nrst_i || mclk_i) ? 9'h000 : mlow + {8'h00, ~&mlow};
    lo1 <= (!nrst_i || t1) ? 7'h00 : lo1 + {6'h00, mrise & ~&lo1};
    hi2 <= (!nrst_i || !t2) ? 7'h00 : hi2 + {6'h00, mrise & ~&hi2};
  end
  chk_pd_silent: assert property (
    (tx_powered_down_o & (tx_line_pos_out_o | tx_line_neg_out_o)) == 8'h00)
    else $error("powered down channel drives its line");
  chk_pd_stuck: assert property (
    lo1 >= 7'd68 |-> tx_powered_down_o[1])
    else $error("channel 1 not powered down");
  chk_pd_resume: assert property (
    !host_mode_o && $rose(t1) |-> ##[1:4] !tx_powered_down_o[1])
    else $error("channel 1 power down not ended");
  chk_ones_stuck: assert property (
    !host_mode_o && hi2 >= 7'd18
      |-> tx_line_pos_out_o[2] ^ tx_line_neg_out_o[2])
    else $error("channel 2 not sending all ones");
  chk_rx_pd_all: assert property (
    mlow >= 9'd260 |-> rx_powered_down_o == 8'hFF)
    else $error("receivers up without master clock");
  chk_mon_pins: assert property (
    !host_mode_o && sel != 3'd0 && !monitor_select_pins_i[3]
      && $stable(monitor_select_pins_i)
      |-> chan0_raw_pos_out_o == rx_raw_pos_i[sel]
        && chan0_clock_out_o == (rx_raw_pos_i[sel] ^ rx_raw_neg_i[sel]))
    else $error("channel 0 not showing monitored input");
  chk_strap_kind: assert property (
    $rose(nrst_i) |=> host_mode_o == ($past(host_kind_strap_i) != 2'b00)
      && serial_bus_o == ($past(host_kind_strap_i) == 2'b01))
    else $error("host kind strap decoded wrongly");
  chk_strap_bus: assert property (
    $rose(nrst_i) && host_kind_strap_i == 2'b10
      |=> muxed_bus_o == $past(bus_mux_strap_i)
        && rw_strobe_style_o == $past(bus_style_strap_i))
    else $error("parallel bus straps decoded wrongly");
endmodule

// ===== test/lcc_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
`include "lcc_consts.vh"
module lcc_host_model (
  input wire clock_i,
  output logic [4:0] addr_o = 5'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  // One-cycle access, address and data inverted and strobes cleared once released
  task acc(input w, input [4:0] a, input [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clock_i);
    addr_o <= ~a;
    wdata_o <= ~d;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask
  // Write one expanded register, then back to the primary bank
  task wr_exp(input [4:0] a, input [7:0] d);
    acc(1'b1, `LCC_A_PTR, `LCC_PTR_EXP);
    acc(1'b1, a, d);
    acc(1'b1, `LCC_A_PTR, 8'h00);
  endtask
  // Loopback setup or normal setup of the front end
  task loopback(input on);
    acc(1'b1, `LCC_A_LOOP, {7'h00, on});
    wr_exp(`LCC_FRONT_END_ENABLE_REG, on ? 8'hFE : 8'hFF);
  endtask
endmodule

// ===== test/line_channel_control_tb.sv
// Self-checking bench of the line channel control block
`timescale 1ns/1ps
`include "lcc_consts.vh"
module line_channel_control_tb;
  typedef struct {int sel; logic [7:0] exp;} lcc_note_t;
  reg clock_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [1:0] host_kind_strap_i = 2'b00;
  reg bus_mux_strap_i = 1'b0;
  reg bus_style_strap_i = 1'b0;
  reg mclk_i = 1'b0;
  reg [7:0] chan_tx_clock_i = 8'h00;
  reg [7:0] driver_short_monitor_i = 8'h00;
  reg [7:0] carrier_absent_i = 8'h00;
  reg [3:0] monitor_select_pins_i = 4'h0;
  reg [7:0] rx_raw_pos_i = 8'h00;
  reg [7:0] rx_raw_neg_i = 8'h00;
  reg [7:0] rx_clock_i = 8'h00;
  reg chan0_recovered_clk_i = 1'b0;
  wire [7:0] tx_data_pos_i = 8'h00;
  wire [7:0] tx_data_neg_i = 8'h00;
  wire [4:0] addr_i;
  wire [7:0] wdata_i, rdata_o, tx_line_pos_out_o, tx_line_neg_out_o;
  wire [7:0] tx_powered_down_o, rx_powered_down_o, short_limit_on_o;
  wire wr_i, rd_i, chan0_clock_out_o, chan0_raw_pos_out_o;
  wire chan0_raw_neg_out_o, chan0_los_in_o, host_mode_o, serial_bus_o;
  wire muxed_bus_o, rw_strobe_style_o, irq_n_o;
  reg run = 1'b1;
  reg look = 1'b0;
  reg rd_q = 1'b0;
  reg [7:0] hold_hi = 8'h00;
  reg [7:0] hold_lo = 8'h00;
  reg [31:0] lfsr = 32'h97700697;
  integer err_total = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  lcc_note_t n;
  lcc_note_t notes[$];
  string nm[8] = '{"rd", "c0", "tpd", "rpd", "irq", "ones", "mode", "loop"};
  lcc_host_model host (
    .clock_i(clock_i),
    .addr_o(addr_i),
    .wdata_o(wdata_i),
    .wr_o(wr_i),
    .rd_o(rd_i)
  );
  lcc_top DUT (.*);
  // System clock
  always #5 clock_i = ~clock_i;
  // Master clock every 4 cycles, transmit clocks every 6, with holds
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    mclk_i <= run & (mclk_i ^ cyc[0]);
    chan_tx_clock_i <= (chan_tx_clock_i ^ {8{cyc%3==0}} | hold_hi) & ~hold_lo;
  end
  // Take the oldest note when its result shows
  always @(posedge clock_i) begin
    rd_q <= rd_i;
    if ((rd_q || look) && notes.size() > 0) begin
      n = notes.pop_front();
      check(nm[n.sel], obs(n.sel), n.exp);
    end
  end
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [7:0] obs(input int s);
    case (s)
      0: obs = rdata_o;
      1: obs = {5'h00, chan0_clock_out_o, chan0_raw_pos_out_o,
                chan0_raw_neg_out_o};
      2: obs = tx_powered_down_o;
      3: obs = rx_powered_down_o;
      4: obs = {7'h00, irq_n_o};
      5: obs = tx_line_pos_out_o ^ tx_line_neg_out_o;
      6: obs = {4'h0, host_mode_o, serial_bus_o, muxed_bus_o,
                rw_strobe_style_o};
      default: obs = {5'h00, chan0_clock_out_o, tx_line_pos_out_o[0],
                      tx_line_neg_out_o[0]};
    endcase
  endfunction
  task check(input string what, input [7:0] seen, input [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Note an output value to be looked at on the next edge
  task want(input int s, input [7:0] e);
    @(posedge clock_i);
    notes.push_back('{s, e});
    look <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
  endtask
  task rd_chk(input [4:0] a, input [7:0] e);
    notes.push_back('{0, e});
    host.acc(1'b0, a, 8'h00);
  endtask
  // Reset with given straps, then wait out the internal reset
  task boot(input [1:0] k, input m, input s);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    host_kind_strap_i <= k;
    bus_mux_strap_i <= m;
    bus_style_strap_i <= s;
    monitor_select_pins_i <= 4'h0;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (1001) @(posedge clock_i);
  endtask
  task close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hardware mode, strap codes 01 and 10, then host mode register work
  initial begin
    boot(2'b00, 1'b0, 1'b0);
    want(6, 8'h00);
    for (i = 1; i < 8; i++) begin
      @(posedge clock_i);
      lfsr = nxt(lfsr);
      monitor_select_pins_i <= i[3:0];
      rx_raw_pos_i <= lfsr[7:0];
      rx_raw_neg_i <= lfsr[15:8];
      rx_clock_i <= lfsr[23:16];
      chan0_recovered_clk_i <= ~lfsr[16+i];
      want(1, {5'h00, lfsr[i] ^ lfsr[8+i], lfsr[i], lfsr[8+i]});
    end
    hold_hi <= 8'h04;
    hold_lo <= 8'h02;
    repeat (300) @(posedge clock_i);
    want(5, 8'h04);
    want(2, 8'h02);
    hold_hi <= 8'h00;
    hold_lo <= 8'h00;
    repeat (20) @(posedge clock_i);
    want(2, 8'h00);
    want(5, 8'h00);
    run <= 1'b0;
    repeat (300) @(posedge clock_i);
    want(3, 8'hFF);
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      boot(i == 0 ? 2'b01 : 2'b10, i == 3, i == 2);
      want(6, i == 0 ? 8'h0C : {6'h02, i == 3, i == 2});
    end
    driver_short_monitor_i <= 8'h01;
    host.loopback(1'b0);
    host.acc(1'b1, `LCC_A_PTR, `LCC_PTR_EXP);
    rd_chk(`LCC_FRONT_END_ENABLE_REG, 8'hFF);
    host.acc(1'b1, `LCC_A_PTR, 8'h00);
    rd_chk(`LCC_A_LOOP, 8'h00);
    lfsr = nxt(lfsr);
    host.acc(1'b1, `LCC_A_AONES, lfsr[7:0]);
    rd_chk(`LCC_A_AONES, lfsr[7:0]);
    want(5, lfsr[7:0]);
    host.acc(1'b1, `LCC_A_AONES, 8'h00);
    host.acc(1'b1, `LCC_A_AUTO, 8'h20);
    carrier_absent_i <= 8'h20;
    repeat (4) @(posedge clock_i);
    want(5, 8'h20);
    host.wr_exp(`LCC_TX_POWERDOWN_REG, 8'h80);
    want(2, 8'h80);
    host.wr_exp(`LCC_RX_POWERDOWN_REG, 8'h40);
    want(3, 8'h40);
    rd_chk(`LCC_A_DF, 8'h00);
    host.acc(1'b1, `LCC_A_DFM, 8'hFF);
    rd_chk(`LCC_A_DFM, 8'h00);
    host.acc(1'b1, `LCC_A_GCF, 8'h01);
    host.acc(1'b1, `LCC_A_DFM, 8'h08);
    driver_short_monitor_i <= 8'h0D;
    repeat (4) @(posedge clock_i);
    want(4, 8'h00);
    rd_chk(`LCC_A_DFI, 8'h08);
    rd_chk(`LCC_A_DF, 8'h0D);
    rd_chk(`LCC_A_DFI, 8'h00);
    want(4, 8'h01);
    host.acc(1'b1, `LCC_A_MON, 8'h05);
    host.loopback(1'b1);
    lfsr = nxt(lfsr);
    rx_raw_pos_i <= lfsr[7:0];
    rx_raw_neg_i <= lfsr[15:8];
    chan0_recovered_clk_i <= lfsr[16];
    want(7, {5'h00, lfsr[16], lfsr[5], lfsr[13]});
    host.loopback(1'b0);
    want(1, {5'h00, lfsr[5] ^ lfsr[13], lfsr[5], lfsr[13]});
    host.acc(1'b1, `LCC_A_RST, 8'h00);
    repeat (101) @(posedge clock_i);
    rd_chk(`LCC_A_MON, 8'h00);
    rd_chk(`LCC_A_GCF, 8'h00);
    want(2, 8'h00);
    close_out;
  end
endmodule
bind lcc_top lcc_asserts chk (.*);
